// ==== verilog/bwrc_top.sv ====
// bwrc_top: bus wait, idle, release, refresh and ram emulation control.
// assumes: one 10 MHz clock, synchronous reset, 8-bit register port,
// access requests come from logic on the same clock.
//
// Functional notes
// - area 7 wait code gives zero to three program wait states.
// - area 3 wait code in low wait register, same zero-to-three coding.
// - idle bit set inserts one idle between reads to different areas.
// - bus release granted only while release enable bit is one.
// - precharge bit zero gives one state, one gives two states.
// - match flag sets when counter equals constant.
// - match flag clears only by read as one then write zero.
// - refresh mode zero is cas-before-ras, one is self refresh.
// - refresh wait bit one delays row strobe by one state.
// - refresh enable zero means no refresh control at all.
// - 8-bit counter, read/write, counts internal clock, resets to zero.
// - 8-bit constant register, read/write, resets to all ones.
// - large variant, select zero keeps ram at its normal region.
// - large variant, select one overlays ram onto flash block n.
// - small variant, two block bits pick one 1 kbyte window.
// - wait states only apply to three-state areas.
`timescale 1ns/100ps
`default_nettype none
module bwrc_top
  import bwrc_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire bwrc_access_t access_req,
  output bwrc_timing_t access_timing,
  input wire logic release_req_pin,
  output logic release_grant,
  output logic refresh_request,
  output logic self_refresh,
  output logic ras_strobe,
  output logic cas_strobe,
  output logic [23:0] ram_base,
  output logic [23:0] ram_last
);

  // ************************************************************
  // register state
  // ************************************************************
  logic [7:0] wait_high_q;
  logic [7:0] wait_low_q;
  logic [7:0] bus_high_q;
  logic [7:0] bus_low_q;
  logic [7:0] memory_control_q;
  logic [7:0] counter_q;
  logic [7:0] constant_q;
  logic [7:0] emulation_q;
  logic [7:0] access_state_q;
  logic match_seen_q;
  logic [7:0] rdata_q;
  logic [2:0] last_area_q;
  logic last_read_q;
  logic release_s1_q;
  logic release_s2_q;
  logic release_grant_q;
  bwrc_ref_state_t ref_state_q;
  logic refresh_request_q;
  logic ras_q;
  logic cas_q;

  logic match;
  logic flag_set_pulse;
  logic wr_memory;
  logic refresh_on;

  assign refresh_on = memory_control_q[BWRC_REFRESH_EN_BIT];
  assign wr_memory = reg_wr && (reg_addr == BWRC_MEMORY_CONTROL);
  assign match = (counter_q == constant_q);
  assign flag_set_pulse = match;

  // ************************************************************
  // plain control registers
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      wait_high_q <= BWRC_ZERO_RESET;
      wait_low_q <= BWRC_ZERO_RESET;
      bus_high_q <= BWRC_ZERO_RESET;
      bus_low_q <= BWRC_ZERO_RESET;
      access_state_q <= BWRC_ACCESS_RESET;
      emulation_q <= BWRC_ZERO_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        BWRC_WAIT_CONTROL_HIGH: wait_high_q <= reg_wdata;
        BWRC_WAIT_CONTROL_LOW: wait_low_q <= reg_wdata;
        BWRC_BUS_CONTROL_HIGH: bus_high_q <= reg_wdata;
        BWRC_BUS_CONTROL_LOW: bus_low_q <= reg_wdata;
        BWRC_ACCESS_STATE: access_state_q <= reg_wdata;
        BWRC_RAM_EMULATION: emulation_q <= reg_wdata & BWRC_EMU_MASK;
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // memory control with the match flag
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      memory_control_q <= BWRC_ZERO_RESET;
    end else begin
      if (wr_memory) begin
        memory_control_q[7] <= reg_wdata[7];
        memory_control_q[5:0] <= reg_wdata[5:0];
      end
      if (flag_set_pulse) begin
        memory_control_q[BWRC_MATCH_FLAG_BIT] <= 1'b1;
      end else if (wr_memory && match_seen_q &&
                   !reg_wdata[BWRC_MATCH_FLAG_BIT]) begin
        memory_control_q[BWRC_MATCH_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // arms the clear once software has seen the flag as one
  always_ff @(posedge clock) begin
    if (rst) begin
      match_seen_q <= 1'b0;
    end else if (reg_rd && reg_addr == BWRC_MEMORY_CONTROL) begin
      match_seen_q <= memory_control_q[BWRC_MATCH_FLAG_BIT];
    end else if (wr_memory) begin
      match_seen_q <= 1'b0;
    end
  end

  // ************************************************************
  // refresh interval counter and constant
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      counter_q <= BWRC_ZERO_RESET;
    end else if (reg_wr && reg_addr == BWRC_REFRESH_COUNTER) begin
      counter_q <= reg_wdata;
    end else if (match) begin
      counter_q <= BWRC_ZERO_RESET;
    end else begin
      counter_q <= counter_q + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      constant_q <= BWRC_CONSTANT_RESET;
    end else if (reg_wr && reg_addr == BWRC_REFRESH_CONSTANT) begin
      constant_q <= reg_wdata;
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= BWRC_ZERO_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        BWRC_WAIT_CONTROL_HIGH: rdata_q <= wait_high_q;
        BWRC_WAIT_CONTROL_LOW: rdata_q <= wait_low_q;
        BWRC_BUS_CONTROL_HIGH: rdata_q <= bus_high_q;
        BWRC_BUS_CONTROL_LOW: rdata_q <= bus_low_q;
        BWRC_MEMORY_CONTROL: rdata_q <= memory_control_q;
        BWRC_REFRESH_COUNTER: rdata_q <= counter_q;
        BWRC_REFRESH_CONSTANT: rdata_q <= constant_q;
        BWRC_RAM_EMULATION: rdata_q <= emulation_q;
        BWRC_ACCESS_STATE: rdata_q <= access_state_q;
        default: rdata_q <= BWRC_ZERO_RESET;
      endcase
    end else begin
      rdata_q <= BWRC_ZERO_RESET;
    end
  end
  assign reg_rdata = rdata_q;

  // ************************************************************
  // per-area program wait codes
  // ************************************************************
  // only areas 7 and 3 own a wait field; the other areas never wait,
  // so the sequencer sees one uniform table indexed by area
  logic [1:0] area_wait [8];
  for (genvar gi = 0; gi < 8; gi++) begin : g_area
    if (gi == 7) begin : g_field_high
      assign area_wait[gi] = wait_high_q[BWRC_AREA7_WAIT_LSB +: 2];
    end else if (gi == 3) begin : g_field_low
      assign area_wait[gi] = wait_low_q[BWRC_AREA3_WAIT_LSB +: 2];
    end else begin : g_no_field
      assign area_wait[gi] = 2'h0;
    end
  end

  // ************************************************************
  // access timing for the bus sequencer
  // ************************************************************
  always_comb begin
    access_timing.wait_states = 2'h0;
    if (access_state_q[access_req.area]) begin
      access_timing.wait_states = area_wait[access_req.area];
    end
    access_timing.idle_cycle = access_req.valid && access_req.read &&
      last_read_q && (last_area_q != access_req.area) &&
      bus_high_q[BWRC_IDLE_INSERT_BIT];
    access_timing.precharge_states =
      memory_control_q[BWRC_PRECHARGE_BIT] ? 2'd2 : 2'd1;
  end

  // previous access, for idle insertion
  always_ff @(posedge clock) begin
    if (rst) begin
      last_area_q <= 3'd0;
      last_read_q <= 1'b0;
    end else if (access_req.valid) begin
      last_area_q <= access_req.area;
      last_read_q <= access_req.read;
    end
  end

  // ************************************************************
  // external bus release
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      release_s1_q <= 1'b0;
      release_s2_q <= 1'b0;
    end else begin
      release_s1_q <= release_req_pin;
      release_s2_q <= release_s1_q;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      release_grant_q <= 1'b0;
    end else begin
      release_grant_q <= release_s2_q && bus_low_q[BWRC_RELEASE_EN_BIT] &&
        !access_req.valid;
    end
  end
  assign release_grant = release_grant_q;

  // ************************************************************
  // refresh sequencer
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      refresh_request_q <= 1'b0;
    end else begin
      refresh_request_q <= match && refresh_on;
    end
  end
  assign refresh_request = refresh_request_q;
  assign self_refresh = refresh_on &&
    memory_control_q[BWRC_REFRESH_MODE_BIT];

  // cas-before-ras: cas rises with ras, or one state ahead with the wait bit; both drop, then precharge
  always_ff @(posedge clock) begin
    if (rst) begin
      ref_state_q <= BWRC_REF_IDLE;
      ras_q <= 1'b0;
      cas_q <= 1'b0;
    end else begin
      case (ref_state_q)
        BWRC_REF_IDLE: begin
          ras_q <= 1'b0;
          cas_q <= 1'b0;
          if (refresh_request_q &&
              !memory_control_q[BWRC_REFRESH_MODE_BIT]) begin
            cas_q <= 1'b1;
            if (memory_control_q[BWRC_REFRESH_WAIT_BIT]) begin
              ref_state_q <= BWRC_REF_WAIT;
            end else begin
              ras_q <= 1'b1;
              ref_state_q <= BWRC_REF_RAS;
            end
          end
        end
        BWRC_REF_WAIT: begin
          ras_q <= 1'b1;
          ref_state_q <= BWRC_REF_RAS;
        end
        BWRC_REF_RAS: begin
          ras_q <= 1'b0;
          cas_q <= 1'b0;
          ref_state_q <= BWRC_REF_PRE;
        end
        BWRC_REF_PRE: begin
          if (memory_control_q[BWRC_PRECHARGE_BIT]) begin
            ref_state_q <= BWRC_REF_PRE2;
          end else begin
            ref_state_q <= BWRC_REF_IDLE;
          end
        end
        BWRC_REF_PRE2: ref_state_q <= BWRC_REF_IDLE;
        default: ref_state_q <= BWRC_REF_IDLE;
      endcase
    end
  end
  assign ras_strobe = ras_q;
  assign cas_strobe = cas_q;

  // ************************************************************
  // ram emulation mapping
  // ************************************************************
  always_comb begin
    if (LARGE_VARIANT) begin
      ram_base = BWRC_RAM_BASE_LARGE;
      ram_last = BWRC_RAM_LAST_LARGE;
      if (emulation_q[BWRC_EMU_ENABLE_BIT]) begin
        ram_base = 24'(BWRC_BLOCK_SIZE_LARGE * {21'd0, emulation_q[2:0]});
        ram_last = ram_base + BWRC_BLOCK_SIZE_LARGE - 24'h000001;
      end
    end else begin
      ram_base = BWRC_RAM_BASE_LARGE;
      ram_last = BWRC_RAM_LAST_SMALL;
      if (emulation_q[BWRC_EMU_ENABLE_BIT]) begin
        ram_base = 24'(BWRC_BLOCK_SIZE_SMALL * {22'd0, emulation_q[1:0]});
        ram_last = ram_base + BWRC_BLOCK_SIZE_SMALL - 24'h000001;
      end
    end
  end

endmodule
`default_nettype wire

// ==== inc/bwrc_pkg.sv ====
// bwrc_pkg: register map, field positions, reset values and timing
// constants for the bus wait / refresh control block.
// assumes: 8-bit register port addressed by the low 16 address bits.
package bwrc_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [15:0] BWRC_WAIT_CONTROL_HIGH = 16'hFED2;
  localparam logic [15:0] BWRC_WAIT_CONTROL_LOW = 16'hFED3;
  localparam logic [15:0] BWRC_BUS_CONTROL_HIGH = 16'hFED4;
  localparam logic [15:0] BWRC_BUS_CONTROL_LOW = 16'hFED5;
  localparam logic [15:0] BWRC_MEMORY_CONTROL = 16'hFED6;
  localparam logic [15:0] BWRC_REFRESH_COUNTER = 16'hFED8;
  localparam logic [15:0] BWRC_REFRESH_CONSTANT = 16'hFED9;
  localparam logic [15:0] BWRC_RAM_EMULATION = 16'hFEDB;
  localparam logic [15:0] BWRC_ACCESS_STATE = 16'hFED1;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BWRC_AREA7_WAIT_LSB = 6;
  localparam int BWRC_AREA3_WAIT_LSB = 6;
  localparam int BWRC_IDLE_INSERT_BIT = 7;
  localparam int BWRC_RELEASE_EN_BIT = 7;
  localparam int BWRC_PRECHARGE_BIT = 7;
  localparam int BWRC_MATCH_FLAG_BIT = 6;
  localparam int BWRC_REFRESH_MODE_BIT = 5;
  localparam int BWRC_REFRESH_WAIT_BIT = 4;
  localparam int BWRC_REFRESH_EN_BIT = 3;
  localparam int BWRC_EMU_ENABLE_BIT = 3;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] BWRC_ZERO_RESET = 8'h00;
  localparam logic [7:0] BWRC_CONSTANT_RESET = 8'hFF;
  localparam logic [7:0] BWRC_ACCESS_RESET = 8'hFF;
  localparam logic [7:0] BWRC_EMU_MASK = 8'h0F;

  // ************************************************************
  // address map of the on-chip ram
  // ************************************************************
  localparam logic [23:0] BWRC_RAM_BASE_LARGE = 24'hFFDC00;
  localparam logic [23:0] BWRC_RAM_LAST_LARGE = 24'hFFEBFF;
  localparam logic [23:0] BWRC_RAM_LAST_SMALL = 24'hFFDFFF;
  localparam logic [23:0] BWRC_BLOCK_SIZE_LARGE = 24'h001000;
  localparam logic [23:0] BWRC_BLOCK_SIZE_SMALL = 24'h000400;

  typedef enum logic [2:0] {
    BWRC_REF_IDLE,
    BWRC_REF_WAIT,
    BWRC_REF_RAS,
    BWRC_REF_PRE,
    BWRC_REF_PRE2
  } bwrc_ref_state_t;

  // access request from the bus sequencer
  typedef struct packed {
    logic valid;
    logic read;
    logic [2:0] area;
  } bwrc_access_t;

  // timing settings handed to the bus sequencer
  typedef struct packed {
    logic [1:0] wait_states;
    logic idle_cycle;
    logic [1:0] precharge_states;
  } bwrc_timing_t;

endpackage

// ==== verification/bwrc_far_side.sv ====
// bwrc_far_side: outside bus requester and dram strobe watch.
// assumes: request pin is asynchronous; strobes are active high.
`timescale 1ns/100ps
`default_nettype none
module bwrc_far_side (
  input wire logic clock,
  input wire logic want_bus,
  input wire logic release_grant,
  input wire logic ras_strobe,
  input wire logic cas_strobe,
  output logic release_req_pin,
  output int cbr_count,
  output int order_errors
);
  logic ras_prev;
  // ************************************************************
  // requester and refresh watch
  // ************************************************************
  initial begin
    release_req_pin = 1'b0;
    ras_prev = 1'b0;
    cbr_count = 0;
    order_errors = 0;
  end
  // request held, moves off the clock edge
  always @(posedge clock) begin
    #37;
    release_req_pin = want_bus;
  end
  // column strobe must be high when row strobe rises
  always @(posedge clock) begin
    if (ras_strobe && !ras_prev) begin
      cbr_count <= cbr_count + 1;
      if (!cas_strobe) order_errors <= order_errors + 1;
    end
    ras_prev <= ras_strobe;
  end
endmodule
`default_nettype wire

// ==== verification/bwrc_top_asserts.sv ====
// bwrc_top_asserts: port-level timing checks of the wait/refresh block.
// assumes: bound into bwrc_top; one clock, synchronous rst.
`timescale 1ns/100ps
`default_nettype none
module bwrc_top_asserts
  import bwrc_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire bwrc_access_t access_req,
  input wire bwrc_timing_t access_timing,
  input wire logic release_req_pin,
  input wire logic release_grant,
  input wire logic refresh_request,
  input wire logic self_refresh,
  input wire logic ras_strobe,
  input wire logic cas_strobe,
  input wire logic [23:0] ram_base,
  input wire logic [23:0] ram_last
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ************************************************************
  // properties
  // ************************************************************
  a_rdata_quiet: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_refresh_pulse: assert property (
    refresh_request |=> !refresh_request)
    else $error("refresh request longer than one cycle");
  a_cbr_cas: assert property (
    refresh_request && !self_refresh |=> cas_strobe)
    else $error("no column strobe after refresh request");
  a_ras_window: assert property (
    refresh_request && !self_refresh |-> ##[1:2] ras_strobe)
    else $error("row strobe late in refresh");
  a_ras_with_cas: assert property (
    $rose(ras_strobe) |-> cas_strobe)
    else $error("row strobe before column strobe");
  a_grant_cause: assert property (
    $rose(release_grant) |-> $past(release_req_pin, 3))
    else $error("bus granted without request");
  a_precharge_len: assert property (
    access_timing.precharge_states inside {2'h1, 2'h2})
    else $error("precharge length out of range");
  a_emu_home: assert property (
    LARGE_VARIANT && ram_base == BWRC_RAM_BASE_LARGE
    |-> ram_last == BWRC_RAM_LAST_LARGE)
    else $error("normal ram window end wrong");
  a_emu_span: assert property (
    LARGE_VARIANT && ram_base != BWRC_RAM_BASE_LARGE
    |-> ram_last == ram_base + 24'h000FFF && ram_last <= 24'h007FFF)
    else $error("emulation window span wrong");
  a_idle_reads: assert property (
    access_timing.idle_cycle |-> access_req.valid && access_req.read)
    else $error("idle cycle outside a read");
endmodule
bind bwrc_top bwrc_top_asserts #(.LARGE_VARIANT(LARGE_VARIANT))
  bwrc_top_asserts_inst (.clock(clock), .rst(rst), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .access_req(access_req),
  .access_timing(access_timing), .release_req_pin(release_req_pin),
  .release_grant(release_grant), .refresh_request(refresh_request),
  .self_refresh(self_refresh), .ras_strobe(ras_strobe),
  .cas_strobe(cas_strobe), .ram_base(ram_base), .ram_last(ram_last));
`default_nettype wire

// ==== verification/bwrc_top_test.sv ====
// bwrc_top_test: self-checking bench for the wait/refresh block.
// assumes: bwrc_far_side plays the outside requester and dram.
`timescale 1ns/100ps
`default_nettype none
module bwrc_top_test;
  import bwrc_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  bwrc_access_t access_req = '0;
  bwrc_timing_t access_timing;
  logic want_bus = 1'b0;
  logic release_req_pin, release_grant, refresh_request, self_refresh;
  logic ras_strobe, cas_strobe, rd_seen = 1'b0;
  logic [23:0] ram_base, ram_last;
  logic [15:0] rwa[5] = '{BWRC_WAIT_CONTROL_HIGH, BWRC_WAIT_CONTROL_LOW,
    BWRC_BUS_CONTROL_HIGH, BWRC_BUS_CONTROL_LOW, BWRC_REFRESH_CONSTANT};
  logic [7:0] expq[$];
  logic [7:0] v;
  int cbr_count, order_errors, k, j, n;
  int miscompares = 0;
  int n_compared = 0;
  initial forever #50 clock = ~clock;
  bwrc_top bwrc_top_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .access_req(access_req),
    .access_timing(access_timing), .release_req_pin(release_req_pin),
    .release_grant(release_grant), .refresh_request(refresh_request),
    .self_refresh(self_refresh), .ras_strobe(ras_strobe),
    .cas_strobe(cas_strobe), .ram_base(ram_base), .ram_last(ram_last));
  bwrc_far_side bwrc_far_side_inst (.clock(clock), .want_bus(want_bus),
    .release_grant(release_grant), .ras_strobe(ras_strobe),
    .cas_strobe(cas_strobe), .release_req_pin(release_req_pin),
    .cbr_count(cbr_count), .order_errors(order_errors));
  // ************************************************************
  // bus tasks and comparisons
  // ************************************************************
  task automatic chk_port(input logic [23:0] got, input logic [23:0] e);
    n_compared++;
    if (got !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic chk_read(input logic [7:0] got, input logic [7:0] e);
    chk_port({16'h0000, got}, {16'h0000, e});
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    expq.push_back(e);
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask
  // bounded wait; returns lim when no request came
  task automatic wait_req(input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clock);
      cnt++;
    end while (refresh_request !== 1'b1 && cnt < lim);
  endtask
  task automatic wrap_up();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // read answers are matched against the oldest expectation
  always @(posedge clock) begin
    if (rd_seen) chk_read(reg_rdata, expq.pop_front());
    rd_seen <= reg_rd;
  end
  initial begin
    #5000000;
    miscompares++;
    wrap_up();
  end
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    v = $urandom(32'h9786a4db);
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd(BWRC_MEMORY_CONTROL, BWRC_ZERO_RESET);
    rd(BWRC_REFRESH_CONSTANT, BWRC_CONSTANT_RESET);
    rd(BWRC_RAM_EMULATION, BWRC_ZERO_RESET);
    rd(BWRC_ACCESS_STATE, BWRC_ACCESS_RESET);
    rd(16'hFED7, 8'h00);
    chk_port(ram_base, BWRC_RAM_BASE_LARGE);
    $display("end of test: reset values");
    foreach (rwa[i]) begin
      v = $urandom();
      wr(rwa[i], v);
      rd(rwa[i], v);
    end
    wr(BWRC_RAM_EMULATION, 8'hFF);
    rd(BWRC_RAM_EMULATION, BWRC_EMU_MASK);
    $display("end of test: register access");
    for (j = 0; j < 2; j++) begin
      access_req <= {1'b1, 1'b1, (j == 0) ? 3'h7 : 3'h3};
      for (k = 0; k < 4; k++) begin
        wr(rwa[j], 8'(k << 6));
        @(negedge clock);
        chk_port(24'(access_timing.wait_states), 24'(k));
      end
    end
    wr(BWRC_ACCESS_STATE, 8'h77);
    @(negedge clock);
    chk_port(24'(access_timing.wait_states), 24'h0);
    wr(BWRC_ACCESS_STATE, 8'hFF);
    $display("end of test: wait states");
    for (k = 0; k < 2; k++) begin
      wr(BWRC_BUS_CONTROL_HIGH, 8'(k << 7));
      @(posedge clock);
      access_req <= {1'b1, 1'b1, 3'h1};
      @(posedge clock);
      access_req <= {1'b1, 1'b1, 3'h2};
      @(negedge clock);
      chk_port(24'(access_timing.idle_cycle), 24'(k));
    end
    access_req <= '0;
    $display("end of test: idle cycle");
    for (k = 0; k < 2; k++) begin
      wr(BWRC_BUS_CONTROL_LOW, 8'(k << 7));
      want_bus <= 1'b1;
      repeat (6) @(posedge clock);
      chk_port(24'(release_grant), 24'(k));
      want_bus <= 1'b0;
      repeat (6) @(posedge clock);
    end
    $display("end of test: bus release");
    // fixed period and fresh count keep the mode switches off a match
    wr(BWRC_REFRESH_CONSTANT, 8'h10);
    wr(BWRC_REFRESH_COUNTER, 8'h00);
    wr(BWRC_MEMORY_CONTROL, 8'hA8);
    @(negedge clock);
    chk_port(24'(access_timing.precharge_states), 24'h2);
    chk_port(24'(self_refresh), 24'h1);
    wr(BWRC_MEMORY_CONTROL, 8'h20);
    @(negedge clock);
    chk_port(24'(access_timing.precharge_states), 24'h1);
    chk_port(24'(self_refresh), 24'h0);
    wait_req(300, n);
    chk_port(24'(n), 24'(300));
    $display("end of test: refresh modes");
    for (k = 0; k < 2; k++) begin
      wr(BWRC_MEMORY_CONTROL, 8'(8'h08 | (k << 4)));
      wait_req(600, n);
      wait_req(300, n);
      chk_port(24'(n), 24'(8'h10 + 1));
    end
    wr(BWRC_MEMORY_CONTROL, 8'h08);
    rd(BWRC_MEMORY_CONTROL, 8'h48);
    wr(BWRC_MEMORY_CONTROL, 8'h08);
    rd(BWRC_MEMORY_CONTROL, 8'h08);
    wr(BWRC_REFRESH_COUNTER, 8'h0E);
    wait_req(300, n);
    chk_port(24'(n inside {[2:4]}), 24'h1);
    chk_port(24'(cbr_count > 0 && order_errors == 0), 24'h1);
    $display("end of test: refresh timing");
    for (k = 0; k < 8; k++) begin
      wr(BWRC_RAM_EMULATION, 8'(8 + k));
      @(negedge clock);
      chk_port(ram_base, 24'(k) * BWRC_BLOCK_SIZE_LARGE);
      chk_port(ram_last, 24'(k + 1) * BWRC_BLOCK_SIZE_LARGE - 24'h1);
    end
    wr(BWRC_RAM_EMULATION, 8'h07);
    @(negedge clock);
    chk_port(ram_base, BWRC_RAM_BASE_LARGE);
    chk_port(ram_last, BWRC_RAM_LAST_LARGE);
    $display("end of test: ram emulation");
    wrap_up();
  end
endmodule
`default_nettype wire
